// *** ext_access_pkg.sv ***
`default_nettype none
package ext_access_pkg;
   localparam logic [4:0] addr_control = 5'h0d;
   localparam logic [4:0] addr_window = 5'h0e;
   localparam int func_hi = 15;
   localparam int func_lo = 14;
   localparam int code_hi = 4;
   localparam int code_lo = 0;
   localparam logic [1:0] func_address = 2'h0;
   localparam logic [1:0] func_data_fixed = 2'h1;
   localparam logic [1:0] func_data_inc_rw = 2'h2;
   localparam logic [1:0] func_data_inc_wr = 2'h3;
   localparam logic [4:0] own_device_code = 5'h1f;
   localparam logic [15:0] control_reset = 16'h0000;
   localparam logic [15:0] pointer_reset = 16'h0000;
endpackage
`default_nettype wire

// *** ptr_step.sv ***
`timescale 1ns/1ps
`default_nettype none
module ptr_step
   import ext_access_pkg::*;
(
   input wire logic [1:0] func,  // function selector
   input wire logic is_write,    // access is a write
   output logic step             // pointer advances after access
);
   always_comb begin
      case (func)
         func_data_inc_rw: step = 1'b1;
         func_data_inc_wr: step = is_write;
         default: step = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// *** indirect_extended_reg_access.sv ***
`timescale 1ns/1ps
`default_nettype none
module indirect_extended_reg_access
   import ext_access_pkg::*;
(
   input wire logic ref_clk,          // 20 mhz management clock
   input wire logic resetn,           // async active-low reset
   input wire logic mgmt_req,         // one-cycle access strobe
   input wire logic mgmt_write,       // 1 write, 0 read
   input wire logic [4:0] mgmt_addr,  // management register address
   input wire logic [15:0] mgmt_wdata, // write data
   output logic [15:0] mgmt_rdata,    // read data, valid with mgmt_ack
   output logic mgmt_ack,             // one-cycle completion pulse
   output logic ext_req,              // extended register access strobe
   output logic ext_write,            // extended access is a write
   output logic [15:0] ext_addr,      // pointed extended register
   output logic [15:0] ext_wdata,     // extended write data
   input wire logic [15:0] ext_rdata, // extended read data, same cycle
   output logic [15:0] ptr_out        // current pointer value
);
   // -----------------------------------------------------------
   // reset release
   // -----------------------------------------------------------
   logic rst_s1_q, rst_n_q;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // -----------------------------------------------------------
   // state and decode
   // -----------------------------------------------------------
   logic [1:0] func_q, func_d;
   logic [4:0] code_q, code_d;
   logic [15:0] ptr_q, ptr_d;
   logic [15:0] rdata_q, rdata_d;
   logic ack_q, ack_d;
   logic ereq_q, ereq_d;
   logic ewr_q, ewr_d;
   logic [15:0] eaddr_q, eaddr_d;
   logic [15:0] ewdata_q, ewdata_d;
   logic [15:0] ctrl_view;
   logic hit_ctrl, hit_win, honoured, step;

   assign hit_ctrl = mgmt_req && (mgmt_addr == addr_control);
   assign hit_win = mgmt_req && (mgmt_addr == addr_window);
   // other device codes make the window inert; the pointer is untouched
   assign honoured = hit_win && (code_q == own_device_code);

   typedef enum logic [2:0] {
      acc_idle,
      acc_control,
      acc_pointer,
      acc_data,
      acc_refused,
      acc_unmapped
   } access_t;
   access_t kind;

   // one decode feeds every group, so no two groups can disagree on a request
   always_comb begin
      kind = acc_idle;
      if (hit_ctrl) begin
         kind = acc_control;
      end else if (honoured && (func_q == func_address)) begin
         kind = acc_pointer;
      end else if (honoured) begin
         kind = acc_data;
      end else if (hit_win) begin
         kind = acc_refused;
      end else if (mgmt_req) begin
         kind = acc_unmapped;
      end
   end

   ptr_step u_step (
      .func(func_q),
      .is_write(mgmt_write),
      .step(step)
   );

   // -----------------------------------------------------------
   // control register
   // -----------------------------------------------------------
   always_comb begin
      func_d = func_q;
      code_d = code_q;
      if ((kind == acc_control) && mgmt_write) begin
         func_d = mgmt_wdata[func_hi:func_lo];
         code_d = mgmt_wdata[code_hi:code_lo];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         func_q <= control_reset[func_hi:func_lo];
         code_q <= control_reset[code_hi:code_lo];
      end else begin
         func_q <= func_d;
         code_q <= code_d;
      end
   end

   // reserved bits 13:5 are never stored, so they cannot read back anything
   for (genvar b = 0; b < 16; b++) begin : g_view
      if (b >= func_lo) begin : g_func
         assign ctrl_view[b] = func_q[b - func_lo];
      end else if (b <= code_hi) begin : g_code
         assign ctrl_view[b] = code_q[b - code_lo];
      end else begin : g_rsvd
         assign ctrl_view[b] = 1'b0;
      end
   end

   // -----------------------------------------------------------
   // extended-space pointer
   // -----------------------------------------------------------
   always_comb begin
      ptr_d = ptr_q;
      case (kind)
         acc_pointer: begin
            if (mgmt_write) begin
               ptr_d = mgmt_wdata;
            end
         end
         acc_data: begin
            if (step) begin
               // carry is dropped on purpose: ffff steps to 0000
               ptr_d = ptr_q + 16'h0001;
            end
         end
         default: begin
            // refused and unrelated accesses never move the pointer
            ptr_d = ptr_q;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ptr_q <= pointer_reset;
      end else begin
         ptr_q <= ptr_d;
      end
   end

   // -----------------------------------------------------------
   // read reply
   // -----------------------------------------------------------
   always_comb begin
      ack_d = mgmt_req;
      rdata_d = rdata_q;
      case (kind)
         acc_control: begin
            rdata_d = ctrl_view;
         end
         acc_pointer: begin
            rdata_d = ptr_q;
         end
         acc_data: begin
            // extended data is fetched combinationally in the request cycle
            rdata_d = ext_rdata;
         end
         acc_refused, acc_unmapped: begin
            // answered, so the controller never hangs, but carrying nothing
            rdata_d = 16'h0000;
         end
         default: begin
            rdata_d = rdata_q;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= 16'h0000;
         ack_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ack_q <= ack_d;
      end
   end

   // -----------------------------------------------------------
   // extended register access
   // -----------------------------------------------------------
   always_comb begin
      ereq_d = 1'b0;
      ewr_d = 1'b0;
      eaddr_d = eaddr_q;
      ewdata_d = ewdata_q;
      if (kind == acc_data) begin
         ereq_d = 1'b1;
         ewr_d = mgmt_write;
         // the access uses the pointer as it stood before any step
         eaddr_d = ptr_q;
         ewdata_d = mgmt_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ereq_q <= 1'b0;
         ewr_q <= 1'b0;
         eaddr_q <= 16'h0000;
         ewdata_q <= 16'h0000;
      end else begin
         ereq_q <= ereq_d;
         ewr_q <= ewr_d;
         eaddr_q <= eaddr_d;
         ewdata_q <= ewdata_d;
      end
   end

   // -----------------------------------------------------------
   // outputs
   // -----------------------------------------------------------
   assign mgmt_rdata = rdata_q;
   assign mgmt_ack = ack_q;
   assign ext_req = ereq_q;
   assign ext_write = ewr_q;
   assign ext_addr = eaddr_q;
   assign ext_wdata = ewdata_q;
   assign ptr_out = ptr_q;
endmodule
`default_nettype wire

// *** ext_access_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_access_chk import ext_access_pkg::*; (
   input wire logic ref_clk,           // management clock
   input wire logic resetn,            // raw active-low reset
   input wire logic mgmt_req,          // access strobe
   input wire logic mgmt_write,        // access is a write
   input wire logic [4:0] mgmt_addr,   // register address
   input wire logic [15:0] mgmt_wdata, // write data
   input wire logic [15:0] mgmt_rdata, // read data
   input wire logic mgmt_ack,          // completion pulse
   input wire logic ext_req,           // extended access strobe
   input wire logic [15:0] ext_addr,   // extended access address
   input wire logic [15:0] ext_rdata,  // extended read data
   input wire logic [15:0] ptr_out     // current pointer
);
   logic [15:0] ctl_q;
   wire logic [1:0] fn = ctl_q[15:14];
   wire logic hit = mgmt_req && mgmt_addr == addr_window;
   wire logic win = hit && ctl_q[4:0] == own_device_code;
   // shadow of the control register, rebuilt from the writes seen at the ports
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         ctl_q <= 16'h0000;
      else if (mgmt_req && mgmt_write && mgmt_addr == addr_control)
         ctl_q <= mgmt_wdata;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   chk_ack_follows: assert property (mgmt_req |=> mgmt_ack)
      else $error("no ack");
   chk_ctrl_read: assert property (mgmt_req && !mgmt_write && mgmt_addr == addr_control
      |=> mgmt_rdata == {fn, 9'h000, ctl_q[4:0]}) else $error("control readback");
   chk_ptr_load: assert property (win && mgmt_write && fn == func_address
      |=> ptr_out == $past(mgmt_wdata)) else $error("pointer load");
   chk_ptr_fixed: assert property (win && fn == func_data_fixed
      |=> $stable(ptr_out) && ext_req && ext_addr == ptr_out) else $error("fixed mode");
   chk_ptr_both: assert property (win && fn == func_data_inc_rw
      |=> ptr_out == $past(ptr_out) + 16'h0001) else $error("increment mode");
   chk_ptr_wronly: assert property (win && fn == func_data_inc_wr
      |=> ptr_out == $past(ptr_out) + {15'h0000, $past(mgmt_write)}) else $error("write step");
   chk_code_skip: assert property (hit && ctl_q[4:0] != own_device_code
      |=> !ext_req && $stable(ptr_out) && mgmt_rdata == 16'h0000) else $error("not ignored");
   chk_win_view: assert property (win && !mgmt_write
      |=> mgmt_rdata == (fn == func_address ? ptr_out : $past(ext_rdata))) else $error("window");
   cover property (win && fn == func_data_inc_rw);
   cover property (win && mgmt_write && fn == func_address);
   cover property (hit && ctl_q[4:0] != own_device_code);
endmodule
bind indirect_extended_reg_access ext_access_chk u_chk (.ref_clk, .resetn, .mgmt_req,
   .mgmt_write, .mgmt_addr, .mgmt_wdata, .mgmt_rdata, .mgmt_ack, .ext_req, .ext_addr,
   .ext_rdata, .ptr_out);
`default_nettype wire

// *** ext_reg_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_reg_model (
   input wire logic ref_clk,          // management clock
   input wire logic ext_req,          // access strobe
   input wire logic ext_write,        // access is a write
   input wire logic [15:0] ext_addr,  // register written
   input wire logic [15:0] ext_wdata, // data written
   input wire logic [15:0] ptr_out,   // register read
   output logic [15:0] ext_rdata      // read data, combinational
);
   logic [15:0] mem [16];
   // sixteen entries only: higher pointer bits alias, enough to see steps
   assign ext_rdata = mem[ptr_out[3:0]];
   initial for (int i = 0; i < 16; i++) mem[i] = 16'h5a00 + 16'(i);
   always @(posedge ref_clk) if (ext_req && ext_write) mem[ext_addr[3:0]] <= ext_wdata;
endmodule
`default_nettype wire

// *** indirect_extended_reg_access_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module indirect_extended_reg_access_bench import ext_access_pkg::*;;
   logic ref_clk = 1'b0, resetn = 1'b0, mgmt_req = 1'b0, mgmt_write = 1'b0;
   logic [4:0] mgmt_addr = 5'h00;
   logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata, ext_addr, ext_wdata, ext_rdata, ptr_out;
   logic mgmt_ack, ext_req, ext_write;
   int err_count = 0, checks = 0;
   always #25 ref_clk = ~ref_clk;
   indirect_extended_reg_access dut (.ref_clk, .resetn, .mgmt_req, .mgmt_write, .mgmt_addr,
      .mgmt_wdata, .mgmt_rdata, .mgmt_ack, .ext_req, .ext_write, .ext_addr, .ext_wdata,
      .ext_rdata, .ptr_out);
   ext_reg_model far (.ref_clk, .ext_req, .ext_write, .ext_addr, .ext_wdata, .ptr_out, .ext_rdata);
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("wrong value at %0t: %h not %h", $time, s, e);
      end
   endtask
   task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      {mgmt_req, mgmt_write, mgmt_addr, mgmt_wdata} <= {1'b1, w, a, d};
      @(posedge ref_clk);
      mgmt_req <= 1'b0;
      #1 chk(16'(mgmt_ack), 16'h0001);
   endtask
   task automatic ctl(input logic [1:0] f, input logic [4:0] c);
      acc(1'b1, addr_control, {f, 9'h000, c});
   endtask
   task automatic t_control;
      acc(1'b0, addr_control, 16'h0000);
      chk(mgmt_rdata, control_reset);
      acc(1'b1, addr_control, 16'hffff);
      acc(1'b0, addr_control, 16'h0000);
      chk(mgmt_rdata, {func_data_inc_wr, 9'h000, own_device_code});
      acc(1'b0, 5'h1b, 16'h0000);
      chk(mgmt_rdata, 16'h0000);
   endtask
   task automatic t_pointer;
      ctl(func_address, own_device_code);
      acc(1'b1, addr_window, 16'h0003);
      chk(ptr_out, 16'h0003);
      acc(1'b0, addr_window, 16'h0000);
      chk(mgmt_rdata, 16'h0003);
      ctl(func_data_inc_rw, 5'h1e);
      acc(1'b0, addr_window, 16'h0000);
      chk(mgmt_rdata, 16'h0000);
      acc(1'b1, addr_window, 16'h0000);
      chk(ptr_out, 16'h0003);
   endtask
   task automatic t_modes;
      ctl(func_data_fixed, own_device_code);
      acc(1'b0, addr_window, 16'h0000);
      chk(mgmt_rdata, 16'h5a03);
      chk(ptr_out, 16'h0003);
      ctl(func_data_inc_rw, own_device_code);
      acc(1'b1, addr_window, 16'h1234);
      chk(ext_addr, 16'h0003);
      chk(ext_wdata, 16'h1234);
      acc(1'b0, addr_window, 16'h0000);
      chk(mgmt_rdata, 16'h5a04);
      chk(ptr_out, 16'h0005);
      ctl(func_data_inc_wr, own_device_code);
      acc(1'b0, addr_window, 16'h0000);
      chk(ptr_out, 16'h0005);
      acc(1'b1, addr_window, 16'h0000);
      chk(ptr_out, 16'h0006);
      ctl(func_address, own_device_code);
      acc(1'b1, addr_window, 16'hffff);
      ctl(func_data_inc_rw, own_device_code);
      acc(1'b0, addr_window, 16'h0000);
      chk(ptr_out, 16'h0000);
      ctl(func_address, own_device_code);
      acc(1'b1, addr_window, 16'h0003);
      ctl(func_data_fixed, own_device_code);
      acc(1'b0, addr_window, 16'h0000);
      chk(mgmt_rdata, 16'h1234);
   endtask
   task automatic t_reset;
      @(posedge ref_clk);
      resetn <= 1'b0;
      @(posedge ref_clk);
      #1 chk(ptr_out, pointer_reset);
      chk(mgmt_rdata, 16'h0000);
      @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      acc(1'b0, addr_control, 16'h0000);
      chk(mgmt_rdata, control_reset);
      ctl(func_address, own_device_code);
      acc(1'b0, addr_window, 16'h0000);
      chk(mgmt_rdata, pointer_reset);
   endtask
   task automatic print_verdict;
      $display("mismatches %0d of %0d checks", err_count, checks);
      if (err_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_control;
      t_pointer;
      t_modes;
      t_reset;
      print_verdict;
   end
   initial begin
      repeat (400) @(posedge ref_clk);
      err_count++;
      print_verdict;
   end
endmodule
`default_nettype wire
